// ==== bench/cs_sar_model.sv ====
// Behavioural sample-and-hold and approximation array
`timescale 1ns/1ps
module cs_sar_model (
  input  wire logic       clock,
  input  wire logic       analog_enable,
  input  wire logic       sample_hold,
  output logic [9:0]      sar_result
);
  logic [9:0] held = 10'h155;
  logic       flip = 1'b0;
  always @(posedge clock) begin
    flip <= ~flip;
    if (sample_hold)
      held <= held + 10'h001;
  end
  // Powered down: churn so a stale value cannot pass
  assign sar_result = analog_enable ? held : {5{flip, ~flip}};
endmodule : cs_sar_model

// ==== bench/cs_seq_properties.sv ====
// Port checker for the conversion sequencer
`timescale 1ns/1ps
module cs_seq_properties
  import cs_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        analog_enable,
  input wire logic        converter_clock,
  input wire logic        conv_active,
  input wire logic        sample_hold,
  input wire logic        conv_complete,
  input wire logic [4:0]  active_channel
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire rd_ctrl = psel && !pwrite && paddr == CS_CTRL_OFS;
  a_go_while_busy: assert property (conv_active && rd_ctrl |-> prdata[CS_GO_BIT])
    else $error("go bit low while converting");
  a_clk_held_off: assert property (!analog_enable && $past(!analog_enable) |-> !converter_clock)
    else $error("converter clock runs while disabled");
  a_idle_when_off: assert property (!analog_enable && $past(!analog_enable) |-> !conv_active)
    else $error("conversion while disabled");
  a_start_enabled: assert property ($rose(conv_active) |-> analog_enable)
    else $error("start without enable");
  a_sample_pulse: assert property (sample_hold |=> !sample_hold)
    else $error("sample strobe longer than one cycle");
  a_sample_busy: assert property (sample_hold |-> conv_active)
    else $error("sample strobe outside conversion");
  a_end_after_busy: assert property (conv_complete |-> $past(conv_active))
    else $error("completion without conversion");
  a_sel_locked: assert property ($rose(conv_active) |=> $stable(active_channel) [*8])
    else $error("selection moved early in conversion");
endmodule : cs_seq_properties
bind cs_conversion_sequencer cs_seq_properties cs_seq_properties_i (.*);

// ==== bench/tb_conversion_sequencer.sv ====
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_conversion_sequencer;
  import cs_pkg::*;
  logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0]  paddr = 8'h00, trigger_sources = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, analog_enable, converter_clock, half_rate_phase_clock;
  logic        conv_active, sample_hold, conv_complete;
  logic [9:0]  sar_result;
  logic [4:0]  active_channel;
  logic [1:0]  active_reference;
  int          n_fail = 0, checks_done = 0, nconv = 0, run = 0, last_len = 0, n0;
  int          gap = 0, last_gap = 0;
  always #2.5 clock = ~clock;
  cs_conversion_sequencer cs_conversion_sequencer_i (.*);
  cs_sar_model cs_sar_model_i (.*);
  always @(posedge clock) begin
    if (conv_complete) begin
      nconv    <= nconv + 1;
      last_gap <= gap;
      gap      <= 1;
    end else begin
      gap <= gap + 1;
    end
    if (conv_active === 1'b1)
      run <= run + 1;
    else if (run != 0) begin
      last_len <= run;
      run <= 0;
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic guard(input int i);
    if (i >= 300) begin
      n_fail++;
      end_of_test();
    end
  endtask : guard
  // Setup, then hold until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 300);
    guard(i);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_act(input logic lvl);
    int i;
    i = 0;
    while (conv_active !== lvl && i < 300) begin
      @(posedge clock);
      i++;
    end
    guard(i);
    repeat (2) @(posedge clock);
  endtask : wait_act
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    apb(0, CS_CTRL_OFS, 0);
    chk(rd, 32'h0);
    apb(0, 8'h14, 0);
    chk({31'h0, err}, 32'h1);
    apb(1, CS_CTRL_OFS, 32'h40);
    apb(0, CS_CTRL_OFS, 0);
    chk(rd, 32'h0);
    $display("test reset done");
    apb(1, CS_CTRL_OFS, 32'h80);
    apb(1, CS_CTRL_OFS, 32'hC0);
    wait_act(1);
    apb(0, CS_CTRL_OFS, 0);
    chk(rd, 32'hC0);
    apb(1, CS_SEL_OFS, 32'hC3);
    repeat (2) @(posedge clock);
    chk(active_channel, 0);
    wait_act(0);
    chk(last_len, 50);
    chk(active_channel, 3);
    chk(active_reference, 3);
    apb(0, CS_CTRL_OFS, 0);
    chk(rd, 32'h90);
    apb(0, CS_RLO_OFS, 0);
    chk(rd, 32'h56);
    apb(0, CS_RHI_OFS, 0);
    chk(rd, 32'h01);
    $display("test first conversion done");
    apb(1, CS_CTRL_OFS, 32'hD0);
    wait_act(1);
    apb(0, CS_RLO_OFS, 0);
    wait_act(0);
    chk(last_len, 26);
    apb(0, CS_CTRL_OFS, 0);
    chk(rd, 32'h90);
    apb(0, CS_RHI_OFS, 0);
    chk(rd, 32'h01);
    apb(0, CS_RLO_OFS, 0);
    chk(rd, 32'h56);
    apb(0, CS_RHI_OFS, 0);
    $display("test result lock done");
    apb(1, CS_TRIG_OFS, 32'h40);
    apb(1, CS_CTRL_OFS, 32'hB0);
    trigger_sources <= 8'h04;
    wait_act(1);
    trigger_sources <= 8'h00;
    @(posedge clock);
    trigger_sources <= 8'h04;
    wait_act(0);
    chk(last_len, 27);
    repeat (60) @(posedge clock);
    chk(nconv, 3);
    trigger_sources <= 8'h00;
    @(posedge clock);
    trigger_sources <= 8'h04;
    wait_act(1);
    wait_act(0);
    chk(nconv, 4);
    $display("test auto trigger done");
    apb(1, CS_TRIG_OFS, 0);
    n0 = nconv;
    apb(1, CS_CTRL_OFS, 32'hF0);
    repeat (120) @(posedge clock);
    apb(0, CS_CTRL_OFS, 0);
    chk(rd[CS_GO_BIT], 1);
    chk(nconv - n0 >= 3, 1);
    chk(last_gap, 26);
    apb(1, CS_CTRL_OFS, 0);
    apb(0, CS_CTRL_OFS, 0);
    chk(rd, 32'h10);
    chk({converter_clock, half_rate_phase_clock}, 0);
    $display("test free running done");
    apb(1, CS_SEL_OFS, 32'h08);
    apb(1, CS_CTRL_OFS, 32'h80);
    apb(1, CS_CTRL_OFS, 32'hF0);
    repeat (150) @(posedge clock);
    chk(last_gap, 28);
    apb(1, CS_CTRL_OFS, 0);
    apb(1, CS_TRIG_OFS, 32'h40);
    apb(1, CS_CTRL_OFS, 32'hB0);
    // Second pass has no enable toggle, so only the channel forces the long timing
    repeat (2) begin
      trigger_sources <= 8'h00;
      @(posedge clock);
      trigger_sources <= 8'h04;
      wait_act(1);
      wait_act(0);
      chk(last_len, 50);
    end
    $display("test differential done");
    end_of_test();
  end
endmodule : tb_conversion_sequencer

// ==== design/cs_conversion_sequencer.sv ====
// Conversion sequencer: APB registers, prescaler, start and timing control
// Behaviour
// [RULE_01] Go bit starts one conversion, self-clears
// [RULE_02] Channel change waits for running conversion
// [RULE_03] Trigger edge resets prescaler, starts conversion
// [RULE_04] Held level or busy-time edges ignored
// [RULE_05] Trigger flag set regardless of interrupt enables
// [RULE_06] Done flag source runs free after go
// [RULE_07] Go works under auto trigger; reads busy
// [RULE_08] Prescaler divides; held reset while disabled
// [RULE_09] Software keeps converter clock 50-200 kHz
// [RULE_10] User single-ended start on next rising edge
// [RULE_11] Normal 13 cycles, first 25 cycles
// [RULE_12] Sample at 1.5, first at 13.5
// [RULE_13] Completion stores result, sets done, clears go
// [RULE_14] Auto: sample at 2, 13.5 total, 3-cycle sync
// [RULE_15] Differential external-trigger conversions take 25 cycles
// [RULE_16] Free running restarts at once, go high
// [RULE_17] Differential user start 13/14 by phase
// [RULE_18] Software toggles enable between gain conversions
// [RULE_19] Selection buffered, locked while converting
// [RULE_20] Software waits one cycle before reselecting
// [RULE_21] Software beware selection changes under triggers
// [RULE_22] Software updates selection only at safe points
// [RULE_23] Low byte read locks result until high
// [RULE_24] Go zero write ignored; trigger sampled synchronously
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module cs_conversion_sequencer
  import cs_pkg::*;
#(
  parameter int DIV_W = 7
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  trigger_sources,
  input  wire logic [9:0]  sar_result,
  output logic             analog_enable,
  output logic             converter_clock,
  output logic             half_rate_phase_clock,
  output logic             conv_active,
  output logic             sample_hold,
  output logic             conv_complete,
  output logic [4:0]       active_channel,
  output logic [1:0]       active_reference
);

  function automatic logic [DIV_W-1:0] half_ratio(input logic [2:0] s);
    half_ratio = (s == 3'h0) ? DIV_W'(1) : DIV_W'(1) << (s - 3'h1);
  endfunction : half_ratio

  cs_state_t        state;
  cs_state_t        next_state;
  logic             converter_enable;
  logic             auto_trigger_enable;
  logic             conversion_done_flag;
  logic [2:0]       clock_divider_select;
  logic [2:0]       trigger_source_select;
  logic [4:0]       channel_select_field;
  logic [1:0]       reference_select_field;
  logic [DIV_W-1:0] pcnt;
  logic [5:0]       half_cnt;
  logic [5:0]       sh_point;
  logic [5:0]       end_point;
  logic             first_conv;
  logic             trig_prev;
  logic [CS_SYNC_CYCLES-1:0] trig_sync;
  logic [9:0]       result;
  logic             result_locked;

  // APB decode
  wire       acc      = psel & penable;
  wire       wr       = acc & pwrite;
  wire       rd       = acc & ~pwrite;
  wire       hit_ctrl = paddr == CS_CTRL_OFS;
  wire       hit_trig = paddr == CS_TRIG_OFS;
  wire       hit_sel  = paddr == CS_SEL_OFS;
  wire       hit_rlo  = paddr == CS_RLO_OFS;
  wire       hit_rhi  = paddr == CS_RHI_OFS;
  wire       mapped   = hit_ctrl | hit_trig | hit_sel | hit_rlo | hit_rhi;
  wire       wr_ctrl  = wr & hit_ctrl;
  wire       en_wr    = pwdata[CS_EN_BIT];
  // Writing zero to the go bit does nothing
  wire       go_wr    = wr_ctrl & pwdata[CS_GO_BIT]; // [RULE_24]
  wire       done_clr = wr_ctrl & pwdata[CS_DONE_BIT];

  // Prescaler and converter clock edges
  wire       half_tick = pcnt == half_ratio(clock_divider_select) - DIV_W'(1);
  wire       rise_tick = half_tick & ~converter_clock;
  wire       busy      = state == CS_BUSY;
  wire [5:0] half_nx   = half_cnt + 6'd1;
  wire       complete  = busy & half_tick & (half_nx == end_point);
  wire       diff_sel  = active_channel >= CS_DIFF_MIN;
  wire       free_mode = auto_trigger_enable & (trigger_source_select == CS_TSS_FREE);

  // Trigger edge detection in the CPU clock domain
  wire       trig_now  = trigger_sources[trigger_source_select];
  wire       trig_edge = trig_now & ~trig_prev; // [RULE_24]
  wire       trig_ok   = converter_enable & auto_trigger_enable & ~free_mode & ~busy;
  wire       trig_fire = trig_sync[CS_SYNC_CYCLES-1] & trig_ok; // [RULE_04] [RULE_14]
  wire       user_go   = (state == CS_ARMED) & rise_tick; // [RULE_10]
  wire       free_go   = complete & free_mode & converter_enable; // [RULE_06] [RULE_16]
  wire       start     = trig_fire | user_go | free_go;

  // Timing of the conversion about to start
  logic [5:0] next_sh;
  logic [5:0] next_end;
  always_comb begin
    next_sh  = CS_NORM_SH;
    next_end = CS_NORM_END;
    if (trig_fire) begin
      if (diff_sel || first_conv) begin // [RULE_15]
        next_sh  = CS_FIRST_SH;
        next_end = CS_FIRST_END;
      end else begin
        next_sh  = CS_AUTO_SH; // [RULE_14]
        next_end = CS_AUTO_END;
      end
    end else if (free_go) begin
      if (diff_sel) begin // [RULE_17]
        next_sh  = CS_DIFF_SH;
        next_end = CS_DIFF_END;
      end
    end else if (first_conv) begin
      next_sh  = CS_FIRST_SH; // [RULE_11] [RULE_12]
      next_end = CS_FIRST_END;
    end else if (diff_sel && half_rate_phase_clock) begin
      next_sh  = CS_DIFF_SH; // [RULE_17]
      next_end = CS_DIFF_END;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      CS_IDLE: begin
        if (trig_fire) begin
          next_state = CS_BUSY; // [RULE_03]
        end else if (go_wr && converter_enable && en_wr) begin
          next_state = CS_ARMED; // [RULE_01] [RULE_07]
        end
      end
      CS_ARMED: begin
        if (start) begin
          next_state = CS_BUSY;
        end
      end
      CS_BUSY: begin
        if (complete && !free_go) begin
          next_state = CS_IDLE; // [RULE_13]
        end
      end
      default: next_state = CS_IDLE;
    endcase
    if (!converter_enable) begin
      next_state = CS_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= CS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Register writes
  always_ff @(posedge clock) begin
    if (rst) begin
      converter_enable       <= 1'b0;
      auto_trigger_enable    <= 1'b0;
      clock_divider_select   <= CS_DIV_RST;
      trigger_source_select  <= CS_TSS_RST;
      channel_select_field   <= CS_CH_RST;
      reference_select_field <= CS_REF_RST;
    end else begin
      if (wr_ctrl) begin
        converter_enable     <= en_wr;
        auto_trigger_enable  <= pwdata[CS_ATE_BIT];
        clock_divider_select <= pwdata[CS_DIV_LSB +: 3];
      end
      if (wr && hit_trig) begin
        trigger_source_select <= pwdata[CS_TSS_LSB +: 3];
      end
      if (wr && hit_sel) begin
        channel_select_field   <= pwdata[CS_CH_LSB +: 5];
        reference_select_field <= pwdata[CS_REF_LSB +: 2];
      end
    end
  end

  // Done flag: own event sets it regardless of any interrupt enable
  always_ff @(posedge clock) begin
    if (rst) begin
      conversion_done_flag <= 1'b0;
    end else begin
      conversion_done_flag <= (conversion_done_flag & ~done_clr) | complete; // [RULE_05] [RULE_13]
    end
  end

  // Prescaler: reset while disabled and on each accepted trigger
  always_ff @(posedge clock) begin
    if (rst || !converter_enable || trig_fire) begin // [RULE_08] [RULE_03]
      pcnt                  <= '0;
      converter_clock       <= 1'b0;
      half_rate_phase_clock <= 1'b0;
    end else if (half_tick) begin
      pcnt            <= '0;
      converter_clock <= ~converter_clock;
      if (rise_tick) begin
        half_rate_phase_clock <= ~half_rate_phase_clock;
      end
    end else begin
      pcnt <= pcnt + DIV_W'(1);
    end
  end

  // Conversion counter in half converter cycles
  always_ff @(posedge clock) begin
    if (rst || !converter_enable) begin
      half_cnt    <= 6'd0;
      sh_point    <= CS_NORM_SH;
      end_point   <= CS_NORM_END;
      sample_hold <= 1'b0;
    end else begin
      sample_hold <= busy & half_tick & (half_nx == sh_point) & ~complete; // [RULE_12]
      if (start) begin
        half_cnt  <= 6'd0;
        sh_point  <= next_sh;
        end_point <= next_end; // [RULE_11]
      end else if (busy && half_tick) begin
        half_cnt <= half_nx;
      end
    end
  end

  // First conversion after enable rises uses the long timing
  always_ff @(posedge clock) begin
    if (rst) begin
      first_conv <= 1'b0;
    end else if (wr_ctrl && en_wr && !converter_enable) begin
      first_conv <= 1'b1; // [RULE_11]
    end else if (start) begin
      first_conv <= 1'b0;
    end
  end

  // Three-stage pipeline gives the fixed synchronisation delay
  always_ff @(posedge clock) begin
    if (rst) begin
      trig_prev <= 1'b0;
      trig_sync <= '0;
    end else begin
      trig_prev <= trig_now;
      trig_sync <= {trig_sync[CS_SYNC_CYCLES-2:0], trig_edge & trig_ok}; // [RULE_04] [RULE_14]
    end
  end

  // Selection buffer frozen mid-conversion, open in the last cycle
  wire sel_open = !busy || (half_cnt >= end_point - CS_LAST_CYC);
  always_ff @(posedge clock) begin
    if (rst) begin
      active_channel   <= CS_CH_RST;
      active_reference <= CS_REF_RST;
    end else if (sel_open && !start) begin // [RULE_19] [RULE_02]
      active_channel   <= channel_select_field;
      active_reference <= reference_select_field;
    end
  end

  // Result store; low-byte read guards against torn 10-bit reads
  always_ff @(posedge clock) begin
    if (rst) begin
      result        <= 10'h000;
      result_locked <= 1'b0;
    end else begin
      if (complete && !result_locked) begin
        result <= sar_result; // [RULE_13] [RULE_23]
      end
      if (rd && hit_rhi) begin
        result_locked <= 1'b0;
      end else if (rd && hit_rlo) begin
        result_locked <= 1'b1; // [RULE_23]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      conv_complete <= 1'b0;
    end else begin
      conv_complete <= complete;
    end
  end

  // Go bit reads high while armed or converting
  wire        go_rd    = state != CS_IDLE; // [RULE_01] [RULE_07] [RULE_16]
  wire [31:0] ctrl_rd  = {24'h000000, converter_enable, go_rd, auto_trigger_enable,
                          conversion_done_flag, 1'b0, clock_divider_select};
  wire [31:0] trig_rd  = {24'h000000, trigger_source_select, 5'h00};
  wire [31:0] sel_rd   = {24'h000000, reference_select_field, 1'b0, channel_select_field};
  wire [31:0] rlo_rd   = {24'h000000, result[7:0]};
  wire [31:0] rhi_rd   = {30'h00000000, result[9:8]};

  assign prdata = hit_ctrl ? ctrl_rd :
                  hit_trig ? trig_rd :
                  hit_sel  ? sel_rd  :
                  hit_rlo  ? rlo_rd  :
                  hit_rhi  ? rhi_rd  : 32'h00000000;
  assign pready        = 1'b1;
  assign pslverr       = acc & ~mapped;
  assign analog_enable = converter_enable;
  assign conv_active   = busy;

endmodule : cs_conversion_sequencer

// ==== design/cs_pkg.sv ====
// Constants, register map and types for the conversion sequencer
package cs_pkg;
  // Register byte offsets on the APB slave
  localparam logic [7:0] CS_CTRL_OFS = 8'h00;
  localparam logic [7:0] CS_TRIG_OFS = 8'h04;
  localparam logic [7:0] CS_SEL_OFS  = 8'h08;
  localparam logic [7:0] CS_RLO_OFS  = 8'h0C;
  localparam logic [7:0] CS_RHI_OFS  = 8'h10;
  // Control, trigger and select register field positions
  localparam int CS_EN_BIT   = 7;
  localparam int CS_GO_BIT   = 6;
  localparam int CS_ATE_BIT  = 5;
  localparam int CS_DONE_BIT = 4;
  localparam int CS_DIV_LSB  = 0;
  localparam int CS_TSS_LSB  = 5;
  localparam int CS_CH_LSB   = 0;
  localparam int CS_REF_LSB  = 6;
  // Reset values
  localparam logic [2:0] CS_DIV_RST = 3'h0;
  localparam logic [2:0] CS_TSS_RST = 3'h0;
  localparam logic [4:0] CS_CH_RST  = 5'h00;
  localparam logic [1:0] CS_REF_RST = 2'h0;
  // Trigger source code that means free running on the done flag
  localparam logic [2:0] CS_TSS_FREE = 3'h0;
  // Channel codes from this value up are differential
  localparam logic [4:0] CS_DIFF_MIN = 5'h08;
  // CPU cycles of trigger synchronisation
  localparam int CS_SYNC_CYCLES = 3;
  // Conversion figures in converter clock cycles, then in half cycles
  localparam int CS_NORM_CYC  = 13;
  localparam int CS_FIRST_CYC = 25;
  localparam int CS_DIFF_CYC  = 14;
  localparam logic [5:0] CS_NORM_END  = 6'(2 * CS_NORM_CYC);
  localparam logic [5:0] CS_FIRST_END = 6'(2 * CS_FIRST_CYC);
  localparam logic [5:0] CS_DIFF_END  = 6'(2 * CS_DIFF_CYC);
  localparam logic [5:0] CS_AUTO_END  = 6'd27;  // 13.5 cycles
  localparam logic [5:0] CS_NORM_SH   = 6'd3;   // 1.5 cycles
  localparam logic [5:0] CS_FIRST_SH  = 6'd27;  // 13.5 cycles
  localparam logic [5:0] CS_DIFF_SH   = 6'd5;   // 2.5 cycles
  localparam logic [5:0] CS_AUTO_SH   = 6'd4;   // 2 cycles
  localparam logic [5:0] CS_LAST_CYC  = 6'd2;   // one cycle in halves
  typedef enum logic [1:0] {
    CS_IDLE  = 2'b00,
    CS_ARMED = 2'b01,
    CS_BUSY  = 2'b11
  } cs_state_t;
endpackage : cs_pkg
